// ### rtl/tsd_pkg.sv
// shared constants and types for the test and string op decoder
package tsd_pkg;
   localparam logic [7:0] OPC_TEST_RM_REG = 8'h84;   // 1000010w
   localparam logic [7:0] OPC_TEST_IMM_RM = 8'hF6;   // 1111011w
   localparam logic [7:0] OPC_TEST_IMM_ACC = 8'hA8;  // 1010100w
   localparam logic [7:0] OPC_STRING_MOVE = 8'hA4;   // 1010010w
   localparam logic [7:0] OPC_STRING_PORT_OUT = 8'h6E; // 0110111w
   localparam logic [7:0] OPC_STRING_COMPARE = 8'hA6; // 1010011w
   localparam logic [7:0] OPC_STRING_LOAD = 8'hAC;   // 1010110w
   localparam logic [7:0] OPC_REPEAT_PREFIX = 8'hF2; // 11110010
   localparam logic [7:0] OPC_W_MASK = 8'hFE;
   localparam logic [2:0] SUBOP_TEST = 3'h0;
   localparam logic [1:0] MOD_REGISTER = 2'h3;
   localparam logic [7:0] CLK_TEST_RM_REG_REG = 8'h03;
   localparam logic [7:0] CLK_TEST_RM_REG_MEM = 8'h0A;
   localparam logic [7:0] CLK_TEST_IMM_RM_REG = 8'h04;
   localparam logic [7:0] CLK_TEST_IMM_RM_MEM = 8'h0A;
   localparam logic [7:0] CLK_TEST_ACC_BYTE = 8'h03;
   localparam logic [7:0] CLK_TEST_ACC_WORD = 8'h04;
   localparam logic [7:0] CLK_STRING_MOVE = 8'h0E;
   localparam logic [7:0] CLK_STRING_PORT_OUT = 8'h0E;
   localparam logic [7:0] CLK_STRING_COMPARE = 8'h16;
   localparam logic [7:0] CLK_STRING_LOAD = 8'h0C;
   localparam logic [7:0] CLK_REPEAT_BASE = 8'h08;
   localparam logic [7:0] CLK_REPEAT_PER = 8'h08;

   typedef enum logic [3:0] {
      TSD_OP_NONE,
      TSD_OP_TEST_RM_REG,
      TSD_OP_TEST_IMM_RM,
      TSD_OP_TEST_IMM_ACC,
      TSD_OP_STRING_MOVE,
      TSD_OP_STRING_PORT_OUT,
      TSD_OP_STRING_COMPARE,
      TSD_OP_STRING_LOAD,
      TSD_OP_REP_STRING_MOVE,
      TSD_OP_ILLEGAL
   } tsd_op_t;

   typedef struct packed {
      tsd_op_t op;
      logic word;
      logic mem;
      logic flags_only;
      logic [1:0] imm_bytes;
      logic [7:0] modrm;
      logic [15:0] imm;
   } tsd_decode_t;
endpackage : tsd_pkg

// ### rtl/tsd_clock_timer.sv
// execution clock counter for one decoded instruction
`timescale 1ns/1ns
module tsd_clock_timer #(
   parameter int WIDTH = 24
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_count,
   output logic o_busy,
   output logic o_done
);
   logic [WIDTH-1:0] remain;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         remain <= '0;
         o_done <= 1'b0;
      end else if (i_load) begin
         remain <= i_count;
         o_done <= 1'b0;
      end else begin
         o_done <= (remain == {{(WIDTH-1){1'b0}}, 1'b1});
         if (remain != '0) begin
            remain <= remain - 1'b1;
         end
      end
   end

   assign o_busy = (remain != '0);
endmodule : tsd_clock_timer

// ### rtl/tsd_decoder.sv
// decoder and clock timer for the flag-only and test and string operations
// Contract
// RL1: opcode 1000010w with a mod reg r/m byte is the flag-only and test, 3 clocks reg, 10 mem.
// RL2: opcode 1111011w with mod 000 r/m is the immediate test, second immediate byte only if w=1, 4 reg or 10 mem.
// RL3: opcode 1010100w followed by immediate data tests the accumulator, 3 clocks byte, 4 word.
// RL4: opcode 1010010w is the single string move and takes 14 clocks.
// RL5: opcode 0110111w is the string port output through the port pointer register, 14 clocks.
// RL6: opcode 1010011w is the single string compare and takes 22 clocks.
// RL7: opcode 1010110w is the string load into the accumulator, 12 clocks.
// RL8: prefix 11110010 repeats the next string move count register times, 8 plus 8 per pass.
// RL9: where two clock counts are listed, the first is byte width and the second word width.
// RL10: opcode bit 0 selects width, zero byte and one word, setting operand and immediate length.
`timescale 1ns/1ns
module tsd_decoder #(
   parameter int COUNT_WIDTH = 16,
   parameter int TIMER_WIDTH = 24
) (
   input wire logic I_MCLK,
   input wire logic I_RST,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   input wire logic [COUNT_WIDTH-1:0] i_count_register,
   output logic o_byte_ready,
   output tsd_pkg::tsd_decode_t o_decode,
   output logic o_decode_valid,
   output logic o_busy,
   output logic o_done
);
   typedef enum {
      TSD_S_OPCODE,
      TSD_S_MODRM,
      TSD_S_IMM_LO,
      TSD_S_IMM_HI,
      TSD_S_ISSUE,
      TSD_S_EXEC
   } tsd_state_t;

   tsd_state_t state;
   tsd_pkg::tsd_decode_t cur;
   logic rep_pending;
   logic timer_load;
   logic timer_busy;
   logic timer_done;
   logic [TIMER_WIDTH-1:0] timer_count;
   logic take;
   tsd_pkg::tsd_op_t base_op;

   function automatic tsd_pkg::tsd_op_t classify(input logic [7:0] b, input logic rep);
      logic [7:0] m;
      m = b & tsd_pkg::OPC_W_MASK;
      if (m == tsd_pkg::OPC_TEST_RM_REG) classify = tsd_pkg::TSD_OP_TEST_RM_REG; // RL1
      else if (m == tsd_pkg::OPC_TEST_IMM_RM) classify = tsd_pkg::TSD_OP_TEST_IMM_RM; // RL2
      else if (m == tsd_pkg::OPC_TEST_IMM_ACC) classify = tsd_pkg::TSD_OP_TEST_IMM_ACC; // RL3
      else if (m == tsd_pkg::OPC_STRING_MOVE) begin
         classify = rep ? tsd_pkg::TSD_OP_REP_STRING_MOVE : tsd_pkg::TSD_OP_STRING_MOVE; // RL4 RL8
      end
      else if (m == tsd_pkg::OPC_STRING_PORT_OUT) classify = tsd_pkg::TSD_OP_STRING_PORT_OUT; // RL5
      else if (m == tsd_pkg::OPC_STRING_COMPARE) classify = tsd_pkg::TSD_OP_STRING_COMPARE; // RL6
      else if (m == tsd_pkg::OPC_STRING_LOAD) classify = tsd_pkg::TSD_OP_STRING_LOAD; // RL7
      else classify = tsd_pkg::TSD_OP_ILLEGAL;
   endfunction : classify

   // pick byte or word figure
   function automatic logic [7:0] by_width(input logic w, input logic [7:0] b,
                                           input logic [7:0] wd);
      by_width = w ? wd : b; // RL9
   endfunction : by_width

   // flag-only forms update flags and write no result
   function automatic logic is_flag_test(input tsd_pkg::tsd_op_t op);
      is_flag_test = (op == tsd_pkg::TSD_OP_TEST_RM_REG) // RL1
         || (op == tsd_pkg::TSD_OP_TEST_IMM_RM) // RL2
         || (op == tsd_pkg::TSD_OP_TEST_IMM_ACC); // RL3
   endfunction : is_flag_test

   // immediate bytes after the opcode or modrm, none for other forms
   function automatic logic [1:0] imm_len(input tsd_pkg::tsd_op_t op, input logic w);
      if ((op == tsd_pkg::TSD_OP_TEST_IMM_RM) || (op == tsd_pkg::TSD_OP_TEST_IMM_ACC)) begin
         imm_len = w ? 2'h2 : 2'h1; // RL10
      end else begin
         imm_len = 2'h0;
      end
   endfunction : imm_len

   assign take = i_byte_valid && o_byte_ready;
   // width and length follow the bare opcode; the prefix only picks the repeated form
   assign base_op = classify(i_byte, 1'b0);
   // pure state decode, so the fetch side sees it well before the edge
   assign o_byte_ready = (state == TSD_S_OPCODE) || (state == TSD_S_MODRM)
                         || (state == TSD_S_IMM_LO) || (state == TSD_S_IMM_HI);

   // byte sequencing
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         state <= TSD_S_OPCODE;
         cur <= '0;
      end else begin
         case (state)
            TSD_S_OPCODE: begin
               if (take) begin
                  // a lone prefix only arms the repeat; the opcode comes next
                  if (i_byte != tsd_pkg::OPC_REPEAT_PREFIX) begin
                     cur <= '0;
                     cur.op <= classify(i_byte, rep_pending);
                     cur.word <= i_byte[0]; // RL10
                     cur.flags_only <= is_flag_test(base_op); // RL1 RL2 RL3
                     cur.imm_bytes <= imm_len(base_op, i_byte[0]); // RL10
                     case (base_op)
                        tsd_pkg::TSD_OP_TEST_RM_REG,
                        tsd_pkg::TSD_OP_TEST_IMM_RM: state <= TSD_S_MODRM;
                        tsd_pkg::TSD_OP_TEST_IMM_ACC: state <= TSD_S_IMM_LO; // RL3
                        default: state <= TSD_S_ISSUE;
                     endcase
                  end
               end
            end
            TSD_S_MODRM: begin
               if (take) begin
                  cur.modrm <= i_byte;
                  // mod 11 names a register, every other mod a memory operand
                  cur.mem <= (i_byte[7:6] != tsd_pkg::MOD_REGISTER);
                  if (cur.op == tsd_pkg::TSD_OP_TEST_IMM_RM) begin
                     // other reg fields belong to other ops sharing the opcode
                     if (i_byte[5:3] != tsd_pkg::SUBOP_TEST) begin
                        cur.op <= tsd_pkg::TSD_OP_ILLEGAL; // RL2
                        cur.imm_bytes <= 2'd0;
                        state <= TSD_S_ISSUE;
                     end else begin
                        state <= TSD_S_IMM_LO; // RL2
                     end
                  end else begin
                     state <= TSD_S_ISSUE; // RL1
                  end
               end
            end
            TSD_S_IMM_LO: begin
               if (take) begin
                  cur.imm[7:0] <= i_byte;
                  state <= cur.word ? TSD_S_IMM_HI : TSD_S_ISSUE; // RL2 RL10
               end
            end
            TSD_S_IMM_HI: begin
               if (take) begin
                  cur.imm[15:8] <= i_byte;
                  state <= TSD_S_ISSUE;
               end
            end
            TSD_S_ISSUE: begin
               state <= TSD_S_EXEC;
            end
            TSD_S_EXEC: begin
               if (o_done || !timer_busy) begin
                  state <= TSD_S_OPCODE;
               end
            end
            default: state <= TSD_S_OPCODE;
         endcase
      end
   end

   // prefix stays armed only until the next opcode byte
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         rep_pending <= 1'b0;
      end else if (take && (state == TSD_S_OPCODE)) begin
         rep_pending <= (i_byte == tsd_pkg::OPC_REPEAT_PREFIX); // RL8
      end
   end

   // execution clock count for the issued op
   always_comb begin
      timer_count = '0;
      case (cur.op)
         tsd_pkg::TSD_OP_TEST_RM_REG: timer_count = TIMER_WIDTH'(cur.mem
            ? tsd_pkg::CLK_TEST_RM_REG_MEM : tsd_pkg::CLK_TEST_RM_REG_REG); // RL1
         tsd_pkg::TSD_OP_TEST_IMM_RM: timer_count = TIMER_WIDTH'(cur.mem
            ? tsd_pkg::CLK_TEST_IMM_RM_MEM : tsd_pkg::CLK_TEST_IMM_RM_REG); // RL2
         tsd_pkg::TSD_OP_TEST_IMM_ACC: timer_count = TIMER_WIDTH'(by_width(cur.word,
            tsd_pkg::CLK_TEST_ACC_BYTE, tsd_pkg::CLK_TEST_ACC_WORD)); // RL3 RL9
         tsd_pkg::TSD_OP_STRING_MOVE: timer_count = TIMER_WIDTH'(tsd_pkg::CLK_STRING_MOVE); // RL4
         tsd_pkg::TSD_OP_STRING_PORT_OUT:
            timer_count = TIMER_WIDTH'(tsd_pkg::CLK_STRING_PORT_OUT); // RL5
         tsd_pkg::TSD_OP_STRING_COMPARE:
            timer_count = TIMER_WIDTH'(tsd_pkg::CLK_STRING_COMPARE); // RL6
         tsd_pkg::TSD_OP_STRING_LOAD: timer_count = TIMER_WIDTH'(tsd_pkg::CLK_STRING_LOAD); // RL7
         // count sampled at issue; later changes do not stretch the run
         tsd_pkg::TSD_OP_REP_STRING_MOVE: timer_count = TIMER_WIDTH'(tsd_pkg::CLK_REPEAT_BASE)
            + TIMER_WIDTH'(tsd_pkg::CLK_REPEAT_PER) * TIMER_WIDTH'(i_count_register); // RL8
         default: timer_count = '0;
      endcase
   end

   // a zero count never loads, so refused ops end without a done pulse
   assign timer_load = (state == TSD_S_ISSUE) && (timer_count != '0);

   // one shared down-counter, loaded once per issued op with a nonzero count
   tsd_clock_timer #(
      .WIDTH(TIMER_WIDTH)
   ) u_timer (
      .i_clk(I_MCLK),
      .i_rst(I_RST),
      .i_load(timer_load),
      .i_count(timer_count),
      .o_busy(timer_busy),
      .o_done(timer_done)
   );

   assign o_done = timer_done;
   // busy covers issue so no byte slips in before the timer loads
   assign o_busy = (state == TSD_S_EXEC) || (state == TSD_S_ISSUE);

   // decoded word, held from issue until the next issue
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         o_decode <= '0;
         o_decode_valid <= 1'b0;
      end else begin
         o_decode_valid <= (state == TSD_S_ISSUE);
         if (state == TSD_S_ISSUE) begin
            o_decode <= cur;
         end
      end
   end
endmodule : tsd_decoder

// ### test/tsd_tb_exp.svh
// expected execution clock counts for each decoded operation
`ifndef TSD_TB_EXP_SVH
`define TSD_TB_EXP_SVH
function automatic logic [23:0] tsd_exp_clk(input tsd_pkg::tsd_op_t op, input logic w,
   input logic m, input logic [15:0] n);
   case (op)
      tsd_pkg::TSD_OP_TEST_RM_REG: return m ? 24'h00_000A : 24'h00_0003;
      tsd_pkg::TSD_OP_TEST_IMM_RM: return m ? 24'h00_000A : 24'h00_0004;
      tsd_pkg::TSD_OP_TEST_IMM_ACC: return w ? 24'h00_0004 : 24'h00_0003;
      tsd_pkg::TSD_OP_STRING_MOVE: return 24'h00_000E;
      tsd_pkg::TSD_OP_STRING_PORT_OUT: return 24'h00_000E;
      tsd_pkg::TSD_OP_STRING_COMPARE: return 24'h00_0016;
      tsd_pkg::TSD_OP_STRING_LOAD: return 24'h00_000C;
      tsd_pkg::TSD_OP_REP_STRING_MOVE: return 24'h00_0008 + {5'h00, n, 3'h0};
      default: return 24'h00_0000;
   endcase
endfunction : tsd_exp_clk
`endif

// ### test/tsd_decoder_sva.sv
// checker for the decoder ports
`timescale 1ns/1ns
`include "tsd_tb_exp.svh"
module tsd_decoder_sva #(
   parameter int COUNT_WIDTH = 16
) (
   input wire logic I_MCLK,
   input wire logic I_RST,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   input wire logic [COUNT_WIDTH-1:0] i_count_register,
   input wire logic o_byte_ready,
   input wire tsd_pkg::tsd_decode_t o_decode,
   input wire logic o_decode_valid,
   input wire logic o_busy,
   input wire logic o_done
);
   tsd_pkg::tsd_op_t op;
   logic [23:0] cyc;
   logic [15:0] last_cnt;
   logic [15:0] n_cap;
   assign op = o_decode.op;
   // count sampled in the issue cycle, held until done
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) last_cnt <= 16'h0000;
      else last_cnt <= 16'(i_count_register);
   end
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) n_cap <= 16'h0000;
      else if (o_decode_valid) n_cap <= last_cnt;
   end
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) cyc <= 24'h00_0000;
      else cyc <= o_decode_valid ? 24'h00_0001 : cyc + 24'h00_0001;
   end
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_RST);
   AST_DONE_CLOCKS: assert property (
      o_done |-> cyc == tsd_exp_clk(op, o_decode.word, o_decode.mem, n_cap))
      else $error("done at wrong clock count");
   AST_BUSY_REFUSE: assert property (o_busy |-> !o_byte_ready)
      else $error("bytes taken while busy");
   AST_ILLEGAL_QUIET: assert property (
      o_decode_valid && op == tsd_pkg::TSD_OP_ILLEGAL |-> !o_done [*4])
      else $error("done after illegal opcode");
   AST_DV_PULSE: assert property (o_decode_valid |=> !o_decode_valid)
      else $error("decode valid longer than one cycle");
   AST_DONE_RELEASE: assert property (o_done |=> !o_done && o_byte_ready && !o_busy)
      else $error("no release after done");
   AST_DECODE_HOLD: assert property ($changed(o_decode) |-> o_decode_valid)
      else $error("decode changed without valid");
   AST_IMM_COUNT: assert property (
      o_decode_valid && (op == tsd_pkg::TSD_OP_TEST_IMM_RM || op == tsd_pkg::TSD_OP_TEST_IMM_ACC)
      |-> o_decode.imm_bytes == (o_decode.word ? 2'h2 : 2'h1))
      else $error("immediate byte count wrong");
   AST_MEM_MOD: assert property (
      o_decode_valid && (op == tsd_pkg::TSD_OP_TEST_RM_REG || op == tsd_pkg::TSD_OP_TEST_IMM_RM)
      |-> o_decode.mem == (o_decode.modrm[7:6] != tsd_pkg::MOD_REGISTER))
      else $error("memory flag does not follow mod");
endmodule : tsd_decoder_sva
bind tsd_decoder tsd_decoder_sva #(.COUNT_WIDTH(COUNT_WIDTH)) u_sva (.I_MCLK(I_MCLK),
   .I_RST(I_RST), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
   .i_count_register(i_count_register), .o_byte_ready(o_byte_ready), .o_decode(o_decode),
   .o_decode_valid(o_decode_valid), .o_busy(o_busy), .o_done(o_done));

// ### test/tsd_fetch_model.sv
// fetch path model feeding opcode bytes
`timescale 1ns/1ns
module tsd_fetch_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_slow,
   input wire logic i_ready,
   output logic o_valid,
   output logic [7:0] o_byte
);
   logic [7:0] q[$];
   logic hiccup;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q.delete();
         o_valid <= 1'b0;
         o_byte <= 8'h00;
         hiccup <= 1'b0;
      end else begin
         if (o_valid && i_ready) void'(q.pop_front());
         hiccup <= ~hiccup;
         // an offered byte stays put until taken
         if (!(o_valid && !i_ready)) begin
            if (q.size() > 0 && !(i_slow && hiccup)) begin
               o_valid <= 1'b1;
               o_byte <= q[0];
            end else begin
               // idle lines flip so stale data never looks valid
               o_valid <= 1'b0;
               o_byte <= ~o_byte;
            end
         end
      end
   end
endmodule : tsd_fetch_model

// ### test/tsd_decoder_tb.sv
// testbench for the test and string op decoder
`timescale 1ns/1ns
`include "tsd_tb_exp.svh"
module tsd_decoder_tb;
   logic I_MCLK = 1'b0;
   logic I_RST = 1'b1;
   logic slow = 1'b0;
   logic [15:0] cnt_reg = 16'h0000;
   logic vld, rdy, dv, busy, done;
   logic [7:0] byt;
   tsd_pkg::tsd_decode_t dec;
   int n_errors = 0;
   int n_checks = 0;
   logic [31:0] rs = 32'h0000_004B;
   logic [7:0] opcs[7] = '{8'h84, 8'hF6, 8'hA8, 8'hA4, 8'h6E, 8'hA6, 8'hAC};
   tsd_decoder dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .i_byte_valid(vld), .i_byte(byt),
      .i_count_register(cnt_reg), .o_byte_ready(rdy), .o_decode(dec), .o_decode_valid(dv),
      .o_busy(busy), .o_done(done));
   tsd_fetch_model fetch (.i_clk(I_MCLK), .i_rst(I_RST), .i_slow(slow), .i_ready(rdy),
      .o_valid(vld), .o_byte(byt));
   initial forever #25 I_MCLK = ~I_MCLK;
   function automatic logic [7:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs[7:0];
   endfunction : rnd
   task automatic chk(string nm, logic [23:0] e, logic [23:0] s);
      n_checks++;
      if (e !== s) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic run(tsd_pkg::tsd_op_t op, logic [7:0] opc, logic [7:0] mr, logic [15:0] im);
      logic w, m, hm, hi, fo;
      int k;
      logic [23:0] e;
      w = opc[0];
      m = mr[7:6] != tsd_pkg::MOD_REGISTER;
      hm = opc[7:1] == 7'h42 || opc[7:1] == 7'h7B;
      // a refused immediate form takes no data bytes
      hi = (opc[7:1] == 7'h7B || opc[7:1] == 7'h54) && op != tsd_pkg::TSD_OP_ILLEGAL;
      fo = op == tsd_pkg::TSD_OP_TEST_RM_REG || op == tsd_pkg::TSD_OP_TEST_IMM_RM
         || op == tsd_pkg::TSD_OP_TEST_IMM_ACC;
      fetch.q.push_back(opc);
      if (hm) fetch.q.push_back(mr);
      if (hi) fetch.q.push_back(im[7:0]);
      if (hi && w) fetch.q.push_back(im[15:8]);
      for (k = 0; k < 300 && dv !== 1'b1; k++) @(negedge I_MCLK);
      if (k == 300) begin
         n_errors++;
         stop_test();
      end
      chk("op", op, dec.op);
      if (op != tsd_pkg::TSD_OP_ILLEGAL) chk("word", w, dec.word);
      if (op != tsd_pkg::TSD_OP_ILLEGAL) chk("flags_only", fo, dec.flags_only);
      if (hi) chk("imm", w ? im : {8'h00, im[7:0]}, dec.imm);
      if (hi) chk("imm_bytes", w ? 2'h2 : 2'h1, dec.imm_bytes);
      if (hm) chk("mem", m, dec.mem);
      if (hm) chk("modrm", mr, dec.modrm);
      // illegal ops must stay quiet for the whole limit
      e = tsd_exp_clk(op, w, m, cnt_reg);
      for (k = 0; k < e + 4 && done !== 1'b1; k++) @(negedge I_MCLK);
      chk("clocks", e == 0 ? 4 : e, k);
      $display("test %s done", op.name());
   endtask : run
   initial begin
      #(50 * 90000);
      n_errors++;
      stop_test();
   end
   initial begin
      logic [7:0] mr;
      repeat (20) @(posedge I_MCLK);
      I_RST <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         // table order matches the op enum, so op = index + 1
         for (int i = 0; i < 14; i++) begin
            @(posedge I_MCLK);
            slow <= r[1];
            mr = rnd();
            mr[7:6] = r[0] ? 2'b11 : 2'b00;
            mr[2] = 1'b0;
            if (i / 2 == 1) mr[5:3] = tsd_pkg::SUBOP_TEST;
            run(tsd_pkg::tsd_op_t'(i / 2 + 1), opcs[i / 2] | 8'(i % 2), mr, {rnd(), rnd()});
         end
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge I_MCLK);
         cnt_reg <= k == 0 ? 16'h0000 : {8'h00, rnd() & 8'h0F};
         @(posedge I_MCLK);
         fetch.q.push_back(8'hF2);
         run(tsd_pkg::TSD_OP_REP_STRING_MOVE, 8'hA4 | 8'(k % 2), 8'h00, 16'h0000);
      end
      fetch.q.push_back(8'hF2);
      run(tsd_pkg::TSD_OP_STRING_LOAD, 8'hAD, 8'h00, 16'h0000);
      run(tsd_pkg::TSD_OP_ILLEGAL, 8'h90, 8'h00, 16'h0000);
      run(tsd_pkg::TSD_OP_ILLEGAL, 8'hF7, 8'hD0, 16'h0000);
      stop_test();
   end
endmodule : tsd_decoder_tb
